// file: mecd_pkg.sv
// What this block does
// - A front-end pass-through command is opcode 0x07, then a register-code byte, then one data byte.
// - The register-code byte carries the front-end register code in bits 7:5 with bits 4:0 zero.
// - Pass-through data goes to the addressed front-end part unchanged and in arrival order.
// - The engine configuration command is opcode 0x20 followed by two bytes that replace the settings.
// - Bits 2:1 of the first setting byte pick 9600 (00), 4800 (01) or 2400 (11) bps; 10 is undefined.
// - Bit 5 of the first setting byte forces a cleardown when set.
// - Bit 4 of the first setting byte turns the echo canceller on when set.
// - Bit 0 of the first setting byte selects originate when set and answer when clear.
// - Bit 3 of byte one enables analog loopback, bit 3 of byte two enables digital loopback.
// - Bits 7:4 of byte two set transmit attenuation, 0 to 22 dB in 2 dB steps, above 1011 infinite.
// - Opcode 0x0e loads tone generator one and is followed by two descriptor bytes.
// - The 16-bit descriptor is the phase step tone generator one adds each sample.
// - The descriptor arrives low byte first, then high byte.
// - Loading the descriptor leaves the generator's enable state alone.
package mecd_pkg;

  // ********************************************************
  // Command codes and field positions
  // ********************************************************
  localparam logic [7:0] OP_FE_PASS = 8'h07;
  localparam logic [7:0] OP_ENGINE_CFG = 8'h20;
  localparam logic [7:0] OP_TONE1_LOAD = 8'h0e;
  localparam int B1_ORIG = 0;
  localparam int B1_SPEED_LO = 1;
  localparam int B1_AL = 3;
  localparam int B1_EC = 4;
  localparam int B1_FC = 5;
  localparam int B2_DL = 3;
  localparam int B2_ATN_LO = 4;
  localparam logic [3:0] ATN_MAX_CODE = 4'hb;
  localparam logic [1:0] SPEED_UNDEF = 2'h2;

  // ********************************************************
  // Register map (byte addresses) and reset values
  // ********************************************************
  localparam logic [7:0] ADDR_CMD_BYTE = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CFG = 8'h08;
  localparam logic [7:0] ADDR_TONE1 = 8'h0c;
  localparam logic [7:0] ADDR_FE_LAST = 8'h10;
  localparam logic [7:0] RST_CFG1 = 8'h00;
  localparam logic [7:0] RST_CFG2 = 8'h00;
  localparam logic [15:0] RST_TONE1 = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_OPCODE = 2'b00,
    ST_BYTE1 = 2'b01,
    ST_BYTE2 = 2'b10
  } mecd_state_e;

  // Decoded engine configuration
  typedef struct packed {
    logic force_cleardown_flag;
    logic echo_cancel_on;
    logic analog_loopback_en;
    logic digital_loopback_en;
    logic originate;
    logic [1:0] line_speed_code;
    logic [3:0] tx_atten_code;
  } mecd_cfg_s;

  // Front-end pass-through write
  typedef struct packed {
    logic [2:0] reg_code;
    logic [7:0] data;
  } mecd_fe_s;

endpackage

// file: mecd_cfg_decode.sv
`timescale 1ns/1ps
`default_nettype none
module mecd_cfg_decode
  import mecd_pkg::*;
(
  input wire logic [7:0] cfg1,
  input wire logic [7:0] cfg2,
  output mecd_cfg_s cfg,
  output logic speed_undef,
  output logic atten_mute,
  output logic [4:0] atten_db
);
  // Field extraction, reserved bits never looked at
  always_comb begin
    cfg.originate = cfg1[B1_ORIG];
    cfg.line_speed_code = cfg1[B1_SPEED_LO +: 2];
    cfg.analog_loopback_en = cfg1[B1_AL];
    cfg.echo_cancel_on = cfg1[B1_EC];
    cfg.force_cleardown_flag = cfg1[B1_FC];
    cfg.digital_loopback_en = cfg2[B2_DL];
    cfg.tx_atten_code = cfg2[B2_ATN_LO +: 4];
    speed_undef = (cfg.line_speed_code == SPEED_UNDEF);
    atten_mute = (cfg.tx_atten_code > ATN_MAX_CODE);
    atten_db = atten_mute ? 5'h00 : {cfg.tx_atten_code, 1'b0};
  end
endmodule
`default_nettype wire

// file: mecd_tone1.sv
`timescale 1ns/1ps
`default_nettype none
module mecd_tone1
  import mecd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic load,
  input wire logic [15:0] phase_step_value,
  output logic [15:0] step_r
);
  logic [15:0] step_nxt;

  // Descriptor store, step_r keeps its value unless load is set
  always_comb begin
    step_nxt = load ? phase_step_value : step_r;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      step_r <= RST_TONE1;
    end else begin
      step_r <= step_nxt;
    end
  end
endmodule
`default_nettype wire

// file: mecd_top.sv
// Implementation choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module mecd_top
  import mecd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic fe_wr_r,
  output logic [2:0] fe_reg_r,
  output logic [7:0] fe_data_r,
  output mecd_cfg_s cfg_r,
  output logic [15:0] tone1_step_r
);
  // ********************************************************
  // Write channel
  // ********************************************************
  logic aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
  logic [7:0] aw_addr_r, aw_addr_nxt;
  logic [7:0] w_byte_r, w_byte_nxt;
  logic w_lane_r, w_lane_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic byte_push;
  logic wr_fire;
  logic awready_r, wready_r;

  // Capture address and data in either order, answer after both
  // Both stay held until the response is taken, so no write slips in
  always_comb begin
    aw_hold_nxt = aw_hold_r;
    w_hold_nxt = w_hold_r;
    aw_addr_nxt = aw_addr_r;
    w_byte_nxt = w_byte_r;
    w_lane_nxt = w_lane_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    byte_push = 1'b0;
    wr_fire = aw_hold_r && w_hold_r && !bvalid_r;
    if (s_axi_awvalid && !aw_hold_r) begin
      aw_hold_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_hold_r) begin
      w_hold_nxt = 1'b1;
      w_byte_nxt = s_axi_wdata[7:0];
      w_lane_nxt = s_axi_wstrb[0];
    end
    if (wr_fire) begin
      bvalid_nxt = 1'b1;
      if (aw_addr_r[7:2] == ADDR_CMD_BYTE[7:2]) begin
        bresp_nxt = RESP_OKAY;
        byte_push = w_lane_r;
      end else begin
        bresp_nxt = RESP_SLVERR;
      end
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
      aw_hold_nxt = 1'b0;
      w_hold_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_byte_r <= 8'h00;
      w_lane_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
    end else begin
      awready_r <= !aw_hold_nxt;
      wready_r <= !w_hold_nxt;
      aw_hold_r <= aw_hold_nxt;
      w_hold_r <= w_hold_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_byte_r <= w_byte_nxt;
      w_lane_r <= w_lane_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // ********************************************************
  // Command decoder
  // ********************************************************
  mecd_state_e st_r, st_nxt;
  logic [7:0] op_r, op_nxt, b1_r, b1_nxt;
  logic [7:0] cfg1_r, cfg1_nxt, cfg2_r, cfg2_nxt;
  logic fe_wr_nxt;
  logic [2:0] fe_reg_nxt;
  logic [7:0] fe_data_nxt;
  logic tone_load;
  logic bad_op_r, bad_op_nxt;
  logic fe_code_err_r, fe_code_err_nxt;

  // Collect three bytes, act only on the last one
  always_comb begin
    st_nxt = st_r;
    op_nxt = op_r;
    b1_nxt = b1_r;
    cfg1_nxt = cfg1_r;
    cfg2_nxt = cfg2_r;
    fe_wr_nxt = 1'b0;
    fe_reg_nxt = fe_reg_r;
    fe_data_nxt = fe_data_r;
    tone_load = 1'b0;
    bad_op_nxt = bad_op_r;
    fe_code_err_nxt = fe_code_err_r;
    if (byte_push) begin
      case (st_r)
        ST_OPCODE: begin
          if (w_byte_r == OP_FE_PASS || w_byte_r == OP_ENGINE_CFG ||
              w_byte_r == OP_TONE1_LOAD) begin
            op_nxt = w_byte_r;
            st_nxt = ST_BYTE1;
          end else begin
            bad_op_nxt = 1'b1;
          end
        end
        ST_BYTE1: begin
          b1_nxt = w_byte_r;
          st_nxt = ST_BYTE2;
        end
        ST_BYTE2: begin
          st_nxt = ST_OPCODE;
          case (op_r)
            OP_FE_PASS: begin
              fe_wr_nxt = 1'b1;
              fe_reg_nxt = b1_r[7:5];
              fe_data_nxt = w_byte_r;
              fe_code_err_nxt = fe_code_err_r | (b1_r[4:0] != 5'h00);
            end
            OP_ENGINE_CFG: begin
              cfg1_nxt = b1_r;
              cfg2_nxt = w_byte_r;
            end
            OP_TONE1_LOAD: begin
              tone_load = 1'b1;
            end
            default: begin
              bad_op_nxt = 1'b1;
            end
          endcase
        end
        default: begin
          st_nxt = ST_OPCODE;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= ST_OPCODE;
      op_r <= 8'h00;
      b1_r <= 8'h00;
      cfg1_r <= RST_CFG1;
      cfg2_r <= RST_CFG2;
      fe_wr_r <= 1'b0;
      fe_reg_r <= 3'h0;
      fe_data_r <= 8'h00;
      bad_op_r <= 1'b0;
      fe_code_err_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      op_r <= op_nxt;
      b1_r <= b1_nxt;
      cfg1_r <= cfg1_nxt;
      cfg2_r <= cfg2_nxt;
      fe_wr_r <= fe_wr_nxt;
      fe_reg_r <= fe_reg_nxt;
      fe_data_r <= fe_data_nxt;
      bad_op_r <= bad_op_nxt;
      fe_code_err_r <= fe_code_err_nxt;
    end
  end

  // ********************************************************
  // Configuration fields and tone generator one
  // ********************************************************
  mecd_cfg_s cfg_dec;
  logic speed_undef, atten_mute;
  logic [4:0] atten_db;

  mecd_cfg_decode u_dec (
    .cfg1(cfg1_r),
    .cfg2(cfg2_r),
    .cfg(cfg_dec),
    .speed_undef(speed_undef),
    .atten_mute(atten_mute),
    .atten_db(atten_db)
  );

  // Registered copy of decoded configuration, one cycle after update
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_r <= '0;
    end else begin
      cfg_r <= cfg_dec;
    end
  end

  mecd_tone1 u_tone1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(tone_load),
    .phase_step_value({w_byte_r, b1_r}),
    .step_r(tone1_step_r)
  );

  // ********************************************************
  // Read channel
  // ********************************************************
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic arready_r;

  // One read at a time, answered one cycle after address acceptance
  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (s_axi_arvalid && !rvalid_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'b00})
        ADDR_CMD_BYTE: rdata_nxt = 32'h0000_0000;
        ADDR_STATUS: rdata_nxt = {24'h000000, atten_db, speed_undef,
                                  atten_mute, 1'b0} |
                                 {28'h0000000, fe_code_err_r, bad_op_r,
                                  st_r};
        ADDR_CFG: rdata_nxt = {16'h0000, cfg2_r, cfg1_r};
        ADDR_TONE1: rdata_nxt = {16'h0000, tone1_step_r};
        ADDR_FE_LAST: rdata_nxt = {21'h000000, fe_reg_r, fe_data_r};
        default: begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
      arready_r <= 1'b1;
    end else begin
      arready_r <= !rvalid_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
endmodule
`default_nettype wire

// file: mecd_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module mecd_monitor
  import mecd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_rvalid,
  input wire logic fe_wr_r,
  input wire logic [7:0] fe_data_r,
  input wire mecd_cfg_s cfg_r,
  input wire logic [15:0] tone1_step_r
);
  logic [3:0] idle_r, idle_nxt;
  // ****
  // Cycles since the last write response
  // ****
  always_comb begin
    idle_nxt = idle_r;
    if (s_axi_bvalid) idle_nxt = 4'h0;
    else if (idle_r != 4'hf) idle_nxt = idle_r + 4'h1;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) idle_r <= 4'hf;
    else idle_r <= idle_nxt;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ****
  // Bus and decoder checks
  // ****
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_no_take: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid
    |=> s_axi_rvalid) else $error("read answer late");
  a_fe_pulse: assert property (fe_wr_r |=> !fe_wr_r)
    else $error("front-end strobe too long");
  a_fe_hold: assert property (!fe_wr_r |-> $stable(fe_data_r))
    else $error("front-end data changed without strobe");
  a_cfg_cause: assert property ($changed(cfg_r) |-> idle_r <= 4'h4)
    else $error("configuration changed with no command");
  a_tone_cause: assert property ($changed(tone1_step_r)
    |-> idle_r <= 4'h4) else $error("phase step changed with no command");
endmodule
bind mecd_top mecd_monitor mon (.*);
`default_nettype wire

// file: mecd_host.sv
`timescale 1ns/1ps
`default_nettype none
module mecd_host
  import mecd_pkg::*;
(
  input wire logic aclk,
  output logic [7:0] s_axi_awaddr,
  output logic [2:0] s_axi_awprot,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic [2:0] s_axi_arprot,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  // Idle bus at time zero
  initial begin
    {s_axi_awaddr, s_axi_awprot, s_axi_awvalid, s_axi_wdata} = '0;
    {s_axi_wstrb, s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
    {s_axi_arprot, s_axi_arvalid, s_axi_rready} = '0;
  end
  // Write one word; response ready held back for st cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input int st, output logic [1:0] r);
    logic ta, tw, tb;
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    forever begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid && s_axi_bready;
      r = s_axi_bresp;
      @(posedge aclk);
      n++;
      if (ta) s_axi_awvalid <= 1'b0;
      if (ta) s_axi_awaddr <= ~a;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tw) s_axi_wdata <= ~d;
      s_axi_bready <= !tb && n > st;
      if (tb) break;
    end
  endtask
  // Read one word
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic ta, tr;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    forever begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid && s_axi_rready;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (ta) s_axi_araddr <= ~a;
      s_axi_rready <= !tr;
      if (tr) break;
    end
  endtask
  // Three-byte command: opcode, then the two following bytes
  task automatic cmd(input logic [7:0] o, x, y, input int st);
    logic [1:0] r;
    wr(ADDR_CMD_BYTE, {24'h0, o}, st, r);
    wr(ADDR_CMD_BYTE, {24'h0, x}, st, r);
    wr(ADDR_CMD_BYTE, {24'h0, y}, st, r);
  endtask
endmodule
`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import mecd_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr, fe_data_r;
  logic [2:0] s_axi_awprot, s_axi_arprot, fe_reg_r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, fe_wr_r;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [15:0] tone1_step_r, etone;
  logic [10:0] efe;
  mecd_cfg_s cfg_r, ecfg;
  int seed = 32'hf1096004;
  int mismatches = 0;
  int check_count = 0;
  always #50 aclk = ~aclk;
  mecd_top uut (.*);
  mecd_host host (.*);
  // Compare and count
  task automatic chk(input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  function automatic mecd_cfg_s exp_cfg(logic [7:0] a, logic [7:0] b);
    exp_cfg = '{a[5], a[4], a[3], b[3], a[0], a[2:1], b[7:4]};
  endfunction
  // Let the command land, then compare cfg_r, tone1_step_r and the last front-end register and data
  task automatic settle();
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    chk(32'(cfg_r), 32'(ecfg));
    chk(32'(tone1_step_r), 32'(etone));
    chk(32'({fe_reg_r, fe_data_r}), 32'(efe));
    @(posedge aclk);
  endtask
  task automatic send(input logic [7:0] o, x, y);
    host.cmd(o, x, y, $random(seed) & 3);
    case (o)
      OP_FE_PASS: efe = {x[7:5], y};
      OP_ENGINE_CFG: ecfg = exp_cfg(x, y);
      default: etone = {y, x};
    endcase
    settle();
  endtask
  // Watchdog
  initial begin
    #2000000;
    mismatches++;
    conclude();
  end
  // ****
  // Main sequence
  // ****
  initial begin
    ecfg = '0;
    etone = '0;
    efe = '0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Every speed and attenuation code, reserved bits set
    for (int k = 0; k < 16; k++) begin
      send(OP_ENGINE_CFG, {2'h3, k[1:0], 1'b1, k[1:0], k[0]},
           {k[3:0], ~k[0], 3'h7});
    end
    // Partial command must not change anything
    host.wr(ADDR_CMD_BYTE, {24'h0, OP_ENGINE_CFG}, 0, r);
    host.wr(ADDR_CMD_BYTE, 32'h11, 2, r);
    settle();
    host.wr(ADDR_CMD_BYTE, 32'h98, 0, r);
    ecfg = exp_cfg(8'h11, 8'h98);
    settle();
    // Unknown opcode is dropped and flagged, decoder waits for an opcode
    host.wr(ADDR_CMD_BYTE, 32'h55, 0, r);
    host.rd(ADDR_STATUS, d, r);
    chk(d, 32'h0000_0094);
    host.rd(ADDR_CFG, d, r);
    chk(d, 32'h0000_9811);
    // Unmapped places answer with an error
    host.wr(8'h14, 32'h0, 1, r);
    chk(32'(r), 32'(RESP_SLVERR));
    host.rd(8'h18, d, r);
    chk(32'(r), 32'(RESP_SLVERR));
    // Random mix of the three commands
    for (int i = 0; i < 30; i++) begin
      d = $random(seed);
      case (d[1:0])
        2'h0: send(OP_FE_PASS, {d[10:8], 5'h0}, d[23:16]);
        2'h1: send(OP_TONE1_LOAD, d[15:8], d[23:16]);
        default: send(OP_ENGINE_CFG, d[15:8], d[23:16]);
      endcase
    end
    host.rd(ADDR_TONE1, d, r);
    chk(d, 32'(etone));
    host.rd(ADDR_FE_LAST, d, r);
    chk(d, 32'(efe));
    conclude();
  end
endmodule
`default_nettype wire
